//--- logic/asc_pkg.sv
package asc_pkg;
    // register byte offsets
    localparam logic [7:0] ASC_OFF_CTRL1   = 8'h00;
    localparam logic [7:0] ASC_OFF_CTRL2   = 8'h04;
    localparam logic [7:0] ASC_OFF_DMAC    = 8'h08;
    localparam logic [7:0] ASC_OFF_IRQST   = 8'h0c;
    localparam logic [7:0] ASC_OFF_IRQMSK  = 8'h10;
    localparam logic [7:0] ASC_OFF_RESDATA = 8'h14;
    localparam logic [7:0] ASC_OFF_TRIGIN  = 8'h18;
    localparam logic [7:0] ASC_OFF_BUF0    = 8'h40;
    // control one fields
    localparam int ASC_C1_ON     = 15;
    localparam int ASC_C1_SIDL   = 13;
    localparam int ASC_C1_BORD   = 12;
    localparam int ASC_C1_12B    = 10;
    localparam int ASC_C1_RESULT_FORMAT   = 8;
    localparam int ASC_C1_TSEL   = 5;
    localparam int ASC_C1_TGRP   = 4;
    localparam int ASC_C1_SIMULTANEOUS_SAMPLING = 3;
    localparam int ASC_C1_AUTO_SAMPLE_ENABLE   = 2;
    localparam int ASC_C1_SAMPLE_ENABLE   = 1;
    localparam int ASC_C1_DONE   = 0;
    localparam logic [15:0] ASC_C1_WMASK = 16'hb7fe;
    // control two fields
    localparam int ASC_C2_SCAN   = 10;
    localparam int ASC_C2_CHANNEL_COUNT_SELECT   = 8;
    localparam int ASC_C2_BUFFER_HALF_STATUS   = 7;
    localparam int ASC_C2_CONVERSIONS_PER_INTERRUPT   = 2;
    localparam logic [15:0] ASC_C2_WMASK = 16'he77f;
    // dma control fields
    localparam int ASC_DC_EN     = 8;
    localparam logic [15:0] ASC_DC_WMASK = 16'h0107;
    // interrupt status bits
    localparam int ASC_IRQ_CNT   = 0;
    localparam int ASC_IRQ_DONE  = 1;
    localparam int ASC_IRQ_OVR   = 2;
    // trigger input vector positions
    localparam int ASC_TRG_PIN   = 0;
    localparam int ASC_TRG_TMR3  = 1;
    localparam int ASC_TRG_PWMSE = 2;
    localparam int ASC_TRG_TMR5  = 3;
    localparam int ASC_TRG_CAPM  = 4;
    localparam int ASC_TRG_PWM1  = 5;
    localparam int ASC_TRG_TGO12 = 8;
    localparam int ASC_NTRIG     = 12;
    // timing, buffer depth and response codes
    localparam int ASC_CONV_CYC  = 14;
    localparam int ASC_AUTO_CYC  = 16;
    localparam int ASC_NBUF      = 16;
    localparam logic [31:0] ASC_RESP_OKAY   = 32'h0;
    localparam logic [1:0]  ASC_OKAY = 2'b00;
    localparam logic [1:0]  ASC_SLVERR = 2'b10;
    typedef enum logic [2:0]
    {
        ASC_IDLE = 3'b001,
        ASC_SAMPLE_ENABLE = 3'b010,
        ASC_CONV = 3'b100
    } asc_state_t;
endpackage

//--- logic/asc_seq_ctrl.sv
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module asc_seq_ctrl
    import asc_pkg::*;
(
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite write
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // trigger sources, one-cycle pulses
    input  wire logic [ASC_NTRIG-1:0]   trig_in,
    // converter result, valid at end of conversion
    input  wire logic [15:0]            conv_result,
    // analog front end control
    output logic                        sample_hold_ff,
    output logic                        simul_sample_ff,
    output logic [4:0]                  scan_index_ff,
    // dma side
    output logic                        dma_req_ff,
    output logic [15:0]                 dma_addr_ff,
    input  wire logic                   dma_ack,
    // interrupt
    output logic                        irq_ff
);
    logic [15:0]      ctrl1_ff;
    logic [15:0]      ctrl2_ff;
    logic [15:0]      dmac_ff;
    logic [2:0]       irqst_ff;
    logic [2:0]       irqmsk_ff;
    logic [15:0]      buf_ff [ASC_NBUF];
    logic [3:0]       bufptr_ff;
    logic [4:0]       cnt_ff;
    logic [15:0]      step_ff;
    logic [4:0]       conv_cnt_ff;
    logic [4:0]       auto_cnt_ff;
    logic             unread_ff;
    asc_state_t       state_ff;
    logic             aw_ff, w_ff;
    logic [7:0]       awaddr_ff;
    logic [31:0]      wdata_ff;
    logic [3:0]       wstrb_ff;
    logic             nxt_aw, nxt_w, nxt_bvalid, nxt_rvalid;

    logic             on, manual, trig_hit, conv_start, conv_end, cnt_hit, dma_en;
    logic             wr_do, wr_c1;
    logic [2:0]       tsel;
    logic [15:0]      wr16;
    logic [15:0]      c1_wr;
    logic [2:0]       irq_set;
    logic [31:0]      rd_mux;

    assign on      = ctrl1_ff[ASC_C1_ON];
    assign tsel    = ctrl1_ff[ASC_C1_TSEL +: 3];
    assign dma_en  = dmac_ff[ASC_DC_EN];
    assign manual  = !ctrl1_ff[ASC_C1_TGRP] && tsel == 3'h0;
    assign wr_do   = aw_ff && w_ff && !s_axi_bvalid;
    assign wr16    = {wstrb_ff[1] ? wdata_ff[15:8] : 8'h00, wstrb_ff[0] ? wdata_ff[7:0] : 8'h00};
    assign wr_c1   = wr_do && awaddr_ff == ASC_OFF_CTRL1 && wstrb_ff[1:0] == 2'h3;
    assign c1_wr   = wdata_ff[15:0];
    assign cnt_hit = conv_end && cnt_ff == ctrl2_ff[ASC_C2_CONVERSIONS_PER_INTERRUPT +: 5];
    assign conv_end = state_ff == ASC_CONV && conv_cnt_ff == 5'(ASC_CONV_CYC - 1);

    // trigger decode
    always_comb
    begin
        trig_hit = 1'b0;
        if (!ctrl1_ff[ASC_C1_TGRP])
        begin
            unique case (tsel)
                3'h7: trig_hit = auto_cnt_ff == 5'(ASC_AUTO_CYC - 1);
                3'h6: trig_hit = trig_in[ASC_TRG_CAPM];
                3'h5: trig_hit = 1'b0;
                3'h4: trig_hit = trig_in[ASC_TRG_TMR5];
                3'h3: trig_hit = trig_in[ASC_TRG_PWMSE];
                3'h2: trig_hit = trig_in[ASC_TRG_TMR3];
                3'h1: trig_hit = trig_in[ASC_TRG_PIN];
                3'h0: trig_hit = wr_c1 && !c1_wr[ASC_C1_SAMPLE_ENABLE];
            endcase
        end
        else if (tsel <= 3'h2)
            trig_hit = trig_in[ASC_TRG_PWM1 + int'(tsel)];
        else if (tsel != 3'h7)
            trig_hit = trig_in[ASC_TRG_TGO12 + int'(tsel) - 3];
    end
    assign conv_start = on && state_ff == ASC_SAMPLE_ENABLE && trig_hit;

    // sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !on)
            state_ff <= ASC_IDLE;
        else
        begin
            unique case (state_ff)
                ASC_IDLE: if (ctrl1_ff[ASC_C1_SAMPLE_ENABLE]) state_ff <= ASC_SAMPLE_ENABLE;
                ASC_SAMPLE_ENABLE: if (conv_start) state_ff <= ASC_CONV;
                         else if (!ctrl1_ff[ASC_C1_SAMPLE_ENABLE]) state_ff <= ASC_IDLE;
                ASC_CONV: if (conv_end)
                             state_ff <= ctrl1_ff[ASC_C1_AUTO_SAMPLE_ENABLE] ? ASC_SAMPLE_ENABLE : ASC_IDLE;
                default:  state_ff <= ASC_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || state_ff != ASC_CONV)
            conv_cnt_ff <= 5'h0;
        else
            conv_cnt_ff <= conv_cnt_ff + 5'h1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || state_ff != ASC_SAMPLE_ENABLE)
            auto_cnt_ff <= 5'h0;
        else if (auto_cnt_ff != 5'(ASC_AUTO_CYC - 1))
            auto_cnt_ff <= auto_cnt_ff + 5'h1;
    end

    // control one with hardware sample and done bits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl1_ff <= 16'h0;
        else
        begin
            if (wr_c1)
            begin
                ctrl1_ff[15:1] <= c1_wr[15:1] & ASC_C1_WMASK[15:1];
                if (c1_wr[ASC_C1_12B])
                    ctrl1_ff[ASC_C1_SIMULTANEOUS_SAMPLING] <= 1'b0;
                if (!c1_wr[ASC_C1_DONE])
                    ctrl1_ff[ASC_C1_DONE] <= 1'b0;
            end
            if (conv_start)
            begin
                ctrl1_ff[ASC_C1_DONE] <= 1'b0;
                if (!manual)
                    ctrl1_ff[ASC_C1_SAMPLE_ENABLE] <= 1'b0;
            end
            if (conv_end)
            begin
                ctrl1_ff[ASC_C1_DONE] <= 1'b1;
                if (ctrl1_ff[ASC_C1_AUTO_SAMPLE_ENABLE])
                    ctrl1_ff[ASC_C1_SAMPLE_ENABLE] <= 1'b1;
            end
            if (!on)
                ctrl1_ff[ASC_C1_SAMPLE_ENABLE] <= wr_c1 ? c1_wr[ASC_C1_SAMPLE_ENABLE] : 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl2_ff <= 16'h0;
        else
        begin
            // read-only bits survive a write; a toggle in the same cycle wins
            if (wr_do && awaddr_ff == ASC_OFF_CTRL2)
                ctrl2_ff <= (wr16 & ASC_C2_WMASK) | (ctrl2_ff & ~ASC_C2_WMASK);
            if (cnt_hit)
                ctrl2_ff[ASC_C2_BUFFER_HALF_STATUS] <= !ctrl2_ff[ASC_C2_BUFFER_HALF_STATUS];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            dmac_ff <= 16'h0;
        else if (wr_do && awaddr_ff == ASC_OFF_DMAC)
            dmac_ff <= wr16 & ASC_DC_WMASK;
    end

    // conversion count, buffer pointer, scan index
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !on)
        begin
            cnt_ff        <= 5'h0;
            bufptr_ff     <= 4'h0;
            scan_index_ff <= 5'h0;
        end
        else if (conv_end)
        begin
            cnt_ff        <= cnt_hit ? 5'h0 : cnt_ff + 5'h1;
            bufptr_ff     <= (cnt_hit || dma_en) ? 4'h0 : bufptr_ff + 4'h1;
            if (ctrl2_ff[ASC_C2_SCAN])
                scan_index_ff <= cnt_hit ? 5'h0 : scan_index_ff + 5'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (conv_end)
            buf_ff[dma_en ? 4'h0 : bufptr_ff] <= conv_result;
    end

    // dma request and address
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !dma_en)
            dma_req_ff <= 1'b0;
        else if (conv_end)
            dma_req_ff <= 1'b1;
        else if (dma_ack)
            dma_req_ff <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !dma_en)
        begin
            step_ff     <= 16'h0;
            dma_addr_ff <= 16'h0;
        end
        else if (conv_end)
        begin
            if (ctrl1_ff[ASC_C1_BORD])
            begin
                if (cnt_hit)
                    step_ff <= step_ff + 16'h1;
                dma_addr_ff <= cnt_hit ? step_ff + 16'h1 : step_ff;
            end
            else
                dma_addr_ff <= 16'({scan_index_ff, 7'h0} >> (3'h7 - dmac_ff[2:0]))
                               + (step_ff & ((16'h1 << dmac_ff[2:0]) - 16'h1));
            if (!ctrl1_ff[ASC_C1_BORD] && cnt_hit)
                step_ff <= step_ff + 16'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            simul_sample_ff <= 1'b0;
        else
            simul_sample_ff <= ctrl1_ff[ASC_C1_SIMULTANEOUS_SAMPLING] && !ctrl1_ff[ASC_C1_12B]
                               && ctrl2_ff[ASC_C2_CHANNEL_COUNT_SELECT +: 2] != 2'h0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sample_hold_ff <= 1'b0;
        else
            sample_hold_ff <= state_ff == ASC_SAMPLE_ENABLE;
    end

    // unread tracker for single-buffer overrun
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !dma_en)
            unread_ff <= 1'b0;
        else if (conv_end)
            unread_ff <= 1'b1;
        else if (dma_ack || (s_axi_arvalid && s_axi_arready && s_axi_araddr == ASC_OFF_BUF0))
            unread_ff <= 1'b0;
    end

    // interrupts, set wins over clear
    assign irq_set = {conv_end && dma_en && unread_ff, conv_end, cnt_hit};
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irqst_ff <= 3'h0;
        else if (wr_do && awaddr_ff == ASC_OFF_IRQST)
            irqst_ff <= (irqst_ff & ~wr16[2:0]) | irq_set;
        else
            irqst_ff <= irqst_ff | irq_set;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irqmsk_ff <= 3'h0;
        else if (wr_do && awaddr_ff == ASC_OFF_IRQMSK)
            irqmsk_ff <= wr16[2:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(irqst_ff & irqmsk_ff);
    end

    // axi write channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ff <= 1'b0;
            w_ff  <= 1'b0;
            awaddr_ff <= 8'h0;
            wdata_ff  <= 32'h0;
            wstrb_ff  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ASC_OKAY;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_do)
            begin
                aw_ff <= 1'b0;
                w_ff  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_ff <= ASC_OFF_IRQMSK && awaddr_ff[1:0] == 2'h0)
                                ? ASC_OKAY : ASC_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_awready <= !nxt_aw && !nxt_bvalid;
            s_axi_wready  <= !nxt_w && !nxt_bvalid;
        end
    end
    // ready flags registered from the next held and pending state
    assign nxt_aw     = (aw_ff && !wr_do) || (s_axi_awvalid && s_axi_awready);
    assign nxt_w      = (w_ff && !wr_do) || (s_axi_wvalid && s_axi_wready);
    assign nxt_bvalid = wr_do || (s_axi_bvalid && !s_axi_bready);

    // axi read channel
    always_comb
    begin
        rd_mux = ASC_RESP_OKAY;
        if (s_axi_araddr >= ASC_OFF_BUF0)
            rd_mux = {16'h0, buf_ff[s_axi_araddr[5:2]]};
        else
        begin
            unique case (s_axi_araddr)
                ASC_OFF_CTRL1:   rd_mux = {16'h0, ctrl1_ff};
                ASC_OFF_CTRL2:   rd_mux = {16'h0, ctrl2_ff};
                ASC_OFF_DMAC:    rd_mux = {16'h0, dmac_ff};
                ASC_OFF_IRQST:   rd_mux = {29'h0, irqst_ff};
                ASC_OFF_IRQMSK:  rd_mux = {29'h0, irqmsk_ff};
                ASC_OFF_RESDATA: rd_mux = {16'h0, buf_ff[0]};
                default:         rd_mux = ASC_RESP_OKAY;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= ASC_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= (s_axi_araddr[1:0] == 2'h0 && (s_axi_araddr <= ASC_OFF_RESDATA
                            || (s_axi_araddr >= ASC_OFF_BUF0 && s_axi_araddr < 8'h80)))
                            ? ASC_OKAY : ASC_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
    assign nxt_rvalid = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_arready <= 1'b1;
        else
            s_axi_arready <= !nxt_rvalid;
    end
endmodule

//--- bench/asc_seq_ctrl_asserts.sv
`timescale 1ns/1ns
module asc_seq_ctrl_chk
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // sequencer and dma
    input wire logic        sample_hold_ff,
    input wire logic        dma_req_ff,
    input wire logic        dma_ack
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_holding;
        !sample_hold_ff [*8];
    endsequence
    property p_conv;
        $fell(sample_hold_ff) |=> s_holding;
    endproperty
    a_conv: assert property (p_conv) else $error("sampling resumed mid conversion");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read response dropped");
    property p_awref;
        s_axi_bvalid |-> !s_axi_awready;
    endproperty
    a_awref: assert property (p_awref) else $error("write address taken while answering");
    property p_arref;
        s_axi_arready != s_axi_rvalid;
    endproperty
    a_arref: assert property (p_arref) else $error("read address ready while answering");
    property p_bdone;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bdone: assert property (p_bdone) else $error("write response repeated");
    property p_dmahold;
        dma_req_ff && !dma_ack |=> dma_req_ff;
    endproperty
    a_dmahold: assert property (p_dmahold) else $error("dma request withdrawn");
    property p_dmaack;
        dma_ack |=> !dma_req_ff;
    endproperty
    a_dmaack: assert property (p_dmaack) else $error("dma request kept after ack");
endmodule

bind asc_seq_ctrl asc_seq_ctrl_chk i_asc_seq_ctrl_chk (.aclk, .aresetn, .s_axi_awready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .sample_hold_ff, .dma_req_ff, .dma_ack);

//--- bench/asc_partner.sv
`timescale 1ns/1ns
module asc_partner
    import asc_pkg::*;
(
    // clock and reset
    input wire logic             aclk,
    input wire logic             aresetn,
    // bench control
    input wire logic [11:0]      fire,
    input wire logic [3:0]       ack_wait,
    // design side
    input wire logic             sample_hold_ff,
    input wire logic             dma_req_ff,
    output logic [ASC_NTRIG-1:0] trig_in,
    output logic [15:0]          conv_result,
    output logic                 dma_ack,
    // counters
    output logic [11:0]          n_conv,
    output logic [7:0]           n_req
);
    logic       hold_q;
    logic       req_q;
    logic [3:0] wait_q;
    // result changes as each sampling phase ends, whether or not a conversion follows
    assign conv_result = 16'hc000 | {4'h0, n_conv};
    always_ff @(posedge aclk)
    begin
        hold_q <= sample_hold_ff;
        req_q <= dma_req_ff;
        trig_in <= fire;
        dma_ack <= 1'b0;
        if (!aresetn)
        begin
            n_conv <= '0;
            n_req <= '0;
            wait_q <= '0;
        end
        else
        begin
            if (hold_q && !sample_hold_ff)
                n_conv <= n_conv + 12'h1;
            if (dma_req_ff && !req_q)
                n_req <= n_req + 8'h1;
            // fetch the single buffer long before the next result
            if (dma_req_ff && !dma_ack)
                wait_q <= wait_q + 4'h1;
            if (dma_req_ff && !dma_ack && wait_q == ack_wait)
            begin
                dma_ack <= 1'b1;
                wait_q <= '0;
            end
        end
    end
endmodule

//--- bench/adc_sequencing_control_bench.sv
`timescale 1ns/1ns
module adc_sequencing_control_bench
    import asc_pkg::*;
;
    localparam logic [31:0] ON = 32'h1 << ASC_C1_ON;
    localparam logic [31:0] SAMPLE_ENABLE = 32'h2;
    localparam logic [31:0] DONE = 32'h1;
    localparam logic [31:0] AUTO = (32'h7 << ASC_C1_TSEL) | (32'h1 << ASC_C1_AUTO_SAMPLE_ENABLE) | 32'h3;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata;
    logic [11:0] trig_in, fire = '0, n_conv, base;
    logic [15:0] conv_result, dma_addr_ff;
    logic [4:0]  scan_index_ff;
    logic [7:0]  n_req, r0;
    logic [3:0]  ack_wait = 4'h1;
    logic        sample_hold_ff, simul_sample_ff, dma_req_ff, dma_ack, irq_ff;
    int          mismatches = 0, num_checks = 0, cycles = 0;

    asc_seq_ctrl i_asc_seq_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .trig_in, .conv_result, .sample_hold_ff, .simul_sample_ff, .scan_index_ff,
        .dma_req_ff, .dma_addr_ff, .dma_ack, .irq_ff);
    asc_partner i_asc_partner (.aclk, .aresetn, .fire, .ack_wait, .sample_hold_ff,
        .dma_req_ff, .trig_in, .conv_result, .dma_ack, .n_conv, .n_req);

    always #50 aclk = ~aclk;

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            tally_and_finish;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw)
        begin
            @(posedge aclk);
            if (s_axi_awready)
                pa = 1'b0;
            if (s_axi_wready)
                pw = 1'b0;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        do
            @(posedge aclk);
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge aclk);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rsp = s_axi_rresp;
        chk(s_axi_rdata & m, e);
        @(posedge aclk);
    endtask

    task automatic pulse(input logic [11:0] b);
        fire <= b;
        @(posedge aclk);
        fire <= '0;
    endtask

    task automatic t_regs;
        rd(ASC_OFF_CTRL1, 32'hffff_ffff, 32'h0);
        wr(ASC_OFF_CTRL1, 32'h4801, ASC_OKAY);
        rd(ASC_OFF_CTRL1, 32'hffff_ffff, 32'h0);
        wr(8'h30, 32'h1, ASC_SLVERR);
        wr(ASC_OFF_BUF0, 32'h1, ASC_SLVERR);
        rd(8'h20, 32'hffff_ffff, 32'h0);
        chk(rsp, ASC_SLVERR);
    endtask

    task automatic t_manual;
        wr(ASC_OFF_CTRL1, ON, ASC_OKAY);
        wr(ASC_OFF_CTRL1, ON | SAMPLE_ENABLE | DONE, ASC_OKAY);
        cyc(2);
        chk(sample_hold_ff, 1'b1);
        rd(ASC_OFF_CTRL1, 32'h3, 32'h2);
        cyc(20);
        rd(ASC_OFF_CTRL1, 32'h3, 32'h2);
        wr(ASC_OFF_CTRL1, ON | DONE, ASC_OKAY);
        rd(ASC_OFF_CTRL1, 32'h3, 32'h0);
        cyc(20);
        rd(ASC_OFF_CTRL1, 32'h3, 32'h1);
        chk(sample_hold_ff, 1'b0);
        rd(ASC_OFF_BUF0, 32'hffff, 32'hc000 | n_conv);
        wr(ASC_OFF_CTRL1, ON | SAMPLE_ENABLE | DONE, ASC_OKAY);
        cyc(3);
        rd(ASC_OFF_CTRL1, 32'h3, 32'h3);
        wr(ASC_OFF_CTRL1, DONE, ASC_OKAY);
        cyc(10);
    endtask

    task automatic t_trig;
        int  b;
        logic rsv;
        for (int g = 0; g < 2; g++)
            for (int c = 0; c < 8; c++)
            begin
                if (g == 0 && c == 0)
                    continue;
                rsv = (g == 1) ? (c == 7) : (c == 5);
                b = (g == 1) ? ASC_TRG_PWM1 + c : (c == 6) ? ASC_TRG_CAPM : c - 1;
                wr(ASC_OFF_CTRL1, ON | SAMPLE_ENABLE | (g << ASC_C1_TGRP) | (c << ASC_C1_TSEL), ASC_OKAY);
                cyc(3);
                if (!(g == 0 && c == 7))
                begin
                    pulse(rsv ? 12'hfff : ~(12'h1 << b));
                    cyc(3);
                    rd(ASC_OFF_CTRL1, 32'h3, 32'h2);
                    pulse(12'h1 << b);
                end
                cyc(40);
                rd(ASC_OFF_CTRL1, 32'h3, rsv ? 32'h2 : 32'h1);
            end
        wr(ASC_OFF_CTRL1, DONE, ASC_OKAY);
    endtask

    task automatic t_sim(input logic [31:0] c2, input logic [31:0] c1, input logic e);
        wr(ASC_OFF_CTRL2, c2, ASC_OKAY);
        wr(ASC_OFF_CTRL1, c1 | (32'h1 << ASC_C1_SIMULTANEOUS_SAMPLING), ASC_OKAY);
        cyc(2);
        chk(simul_sample_ff, e);
    endtask

    task automatic t_count;
        wr(ASC_OFF_IRQST, 32'h7, ASC_OKAY);
        wr(ASC_OFF_IRQMSK, 32'h1, ASC_OKAY);
        wr(ASC_OFF_CTRL2, (32'h2 << ASC_C2_CONVERSIONS_PER_INTERRUPT) | (32'h1 << ASC_C2_SCAN), ASC_OKAY);
        base = n_conv;
        wr(ASC_OFF_CTRL1, ON | AUTO, ASC_OKAY);
        while (!irq_ff)
            @(posedge aclk);
        chk(n_conv - base, 32'h3);
        chk(scan_index_ff, 32'h0);
        for (int k = 0; k < 3; k++)
            rd(ASC_OFF_BUF0 + 8'(4 * k), 32'hffff, 32'hc000 | (base + 12'(k + 1)));
        rd(ASC_OFF_IRQST, 32'h1, 32'h1);
        wr(ASC_OFF_IRQST, 32'h1, ASC_OKAY);
        cyc(2);
        chk(irq_ff, 1'b0);
        while (n_conv != base + 12'h4)
            @(posedge aclk);
        cyc(15);
        rd(ASC_OFF_BUF0, 32'hffff, 32'hc000 | (base + 12'h4));
        chk(n_req, 32'h0);
        wr(ASC_OFF_CTRL1, DONE, ASC_OKAY);
        cyc(2);
        chk(sample_hold_ff, 1'b0);
        base = n_conv;
        pulse(12'hfff);
        cyc(40);
        chk(n_conv, base);
        rd(ASC_OFF_IRQST, 32'h2, 32'h2);
        chk(irq_ff, 1'b0);
    endtask

    task automatic t_dma(input logic [31:0] c1, input logic [31:0] c2, input logic [31:0] dc,
                         input logic [15:0] ea);
        wr(ASC_OFF_DMAC, 32'h0, ASC_OKAY);
        wr(ASC_OFF_DMAC, dc, ASC_OKAY);
        wr(ASC_OFF_CTRL2, c2, ASC_OKAY);
        wr(ASC_OFF_IRQST, 32'h7, ASC_OKAY);
        ack_wait <= 4'h2;
        base = n_conv;
        r0 = n_req;
        wr(ASC_OFF_CTRL1, ON | AUTO | c1, ASC_OKAY);
        while (n_conv != base + 12'h4)
            @(posedge aclk);
        cyc(15);
        wr(ASC_OFF_CTRL1, DONE, ASC_OKAY);
        cyc(5);
        chk(n_req - r0, 32'h4);
        chk(dma_addr_ff, ea);
        rd(ASC_OFF_BUF0, 32'hffff, 32'hc000 | (base + 12'h4));
        rd(ASC_OFF_IRQST, 32'h4, 32'h0);
    endtask

    initial
    begin
        cyc(20);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        t_manual;
        t_trig;
        t_sim(32'h100, 32'h0, 1'b1);
        t_sim(32'h0, 32'h0, 1'b0);
        t_sim(32'h200, 32'h1 << ASC_C1_12B, 1'b0);
        t_count;
        t_dma(32'h1 << ASC_C1_BORD, 32'h1 << ASC_C2_CONVERSIONS_PER_INTERRUPT, 32'h1 << ASC_DC_EN, 16'h2);
        t_dma(32'h0, (32'h1 << ASC_C2_CONVERSIONS_PER_INTERRUPT) | (32'h1 << ASC_C2_SCAN),
              (32'h1 << ASC_DC_EN) | 32'h2, 16'h5);
        tally_and_finish;
    end
endmodule
